/* rtl/pcd_pkg.sv */
// register map, field layout and mode encodings of the pulse command decoder
`default_nettype none
package pcd_pkg;
  localparam logic [7:0] PCD_ADDR_CFG  = 8'h00;
  localparam logic [7:0] PCD_ADDR_GEAR = 8'h04;
  localparam logic [7:0] PCD_ADDR_ENC  = 8'h08;
  localparam logic [7:0] PCD_ADDR_STAT = 8'h0C;
  localparam logic [7:0] PCD_ADDR_POS  = 8'h10;
  localparam logic [7:0] PCD_ADDR_CTRL = 8'h14;
  localparam int PCD_CFG_MODE_LSB = 0;
  localparam int PCD_CFG_PAL_BIT  = 3;
  localparam int PCD_CFG_ANA_BIT  = 4;
  localparam int PCD_CFG_DIR_BIT  = 5;
  localparam int PCD_CFG_DISP_LSB = 8;
  localparam int PCD_DEN_LSB      = 0;
  localparam int PCD_NUM_LSB      = 16;
  localparam int PCD_CTRL_APPLY   = 0;
  localparam int PCD_ST_BLOCK     = 8;
  localparam int PCD_ST_RUN       = 9;
  localparam int PCD_ST_WARN      = 10;
  localparam int PCD_ST_ALARM     = 11;
  localparam int PCD_ST_SW        = 12;
  localparam int PCD_ST_DISP_LSB  = 16;
  localparam logic [2:0] PCD_MODE_RST = 3'h0;
  localparam logic       PCD_PAL_RST  = 1'h0;
  localparam logic       PCD_ANA_RST  = 1'h0;
  localparam logic       PCD_DIR_RST  = 1'h0;
  localparam logic [3:0] PCD_DISP_RST = 4'h0;
  localparam logic [9:0] PCD_GEAR_RST = 10'h001;
  localparam logic [9:0] PCD_GEAR_MIN = 10'h001;
  localparam logic [9:0] PCD_GEAR_MAX = 10'h3E8;
  localparam logic [3:0] PCD_DISP_MAX  = 4'h9;
  localparam logic [3:0] PCD_DISP_TOP  = 4'h9;
  localparam logic [3:0] PCD_DISP_TENS = 4'h6;
  localparam logic [3:0] PCD_DISP_ROLL = 4'h8;
  localparam logic [2:0] PCD_CODE_SW     = 3'h0;
  localparam logic [2:0] PCD_CODE_DUAL_N = 3'h1;
  localparam logic [2:0] PCD_CODE_DUAL_P = 3'h2;
  localparam logic [2:0] PCD_CODE_STEP_N = 3'h3;
  localparam logic [2:0] PCD_CODE_STEP_P = 3'h4;
  localparam logic [2:0] PCD_CODE_QX1    = 3'h5;
  localparam logic [2:0] PCD_CODE_QX2    = 3'h6;
  localparam logic [2:0] PCD_CODE_QX4    = 3'h7;
  localparam logic [31:0] PCD_RES_BASE = 32'h000003E8;
  localparam logic [31:0] PCD_RES_MIN  = 32'h00000064;
  localparam logic [31:0] PCD_RES_MAX  = 32'h000186A0;
  localparam logic [1:0]  PCD_SETTLE   = 2'h3;
  typedef enum logic [6:0] {
    PCD_DUAL_N = 7'h01,
    PCD_DUAL_P = 7'h02,
    PCD_STEP_N = 7'h04,
    PCD_STEP_P = 7'h08,
    PCD_QX1    = 7'h10,
    PCD_QX2    = 7'h20,
    PCD_QX4    = 7'h40
  } pcd_mode_t;
endpackage : pcd_pkg
`default_nettype wire

/* rtl/pcd_top.sv */
// pulse command input decoder with power-up latched settings, ahb-lite slave
//
// Contract
// - command gear denominator held, 1 to 1000
// - encoder gear numerator, denominator held, 1-1000
// - code 0 takes mode from selector switch
// - codes 1-4: dual/step, negative/positive
// - codes 5,6,7: quadrature x1, x2, x4
// - alarm clear: policy 0 blocks until request
// - one bit enables analog inputs
// - direction bit maps forward to ccw/cw
// - display 0-9, unsupported shows top screen
// - step pulse counted, signed by sense
// - cw pulse forward, ccw pulse reverse
// - quadrature forward when ccw lags cw
// - quadrature reverse when ccw leads cw
// - switch on step, off dual
// - switch modes always negative polarity
// - switch and settings taken at power-up and again on a ctrl apply write
// - resolution 1000*num/den within 100..100000
// - out of range warns, reapply with warning alarms
`timescale 1ns/1ps
`default_nettype none
module pcd_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        step_pulse_in,
  input  wire logic        dir_ccw_in,
  input  wire logic        pos_req_in,
  input  wire logic        input_mode_selector_switch,
  input  wire logic        abs_alarm_clr,
  output logic             fwd_step,
  output logic             rev_step,
  output logic             motor_step,
  output logic             motor_cw,
  output logic             analog_en,
  output logic      [3:0]  display_sel,
  output logic             gear_warn,
  output logic             gear_alarm
);
  // bus side
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] hrdata_q;
  logic        hreadyout_q;
  logic        hresp_q;
  // stored settings
  logic [2:0]  cfg_mode_q;
  logic        cfg_pal_q;
  logic        cfg_ana_q;
  logic        cfg_dir_q;
  logic [3:0]  cfg_disp_q;
  logic [9:0]  cden_q;
  logic [9:0]  cnum_q;
  logic [9:0]  eden_q;
  logic [9:0]  enum_q;
  // active copies
  pcd_pkg::pcd_mode_t mode_q;
  pcd_pkg::pcd_mode_t mode_sel;
  logic        pal_q;
  logic        dir_q;
  logic        analog_en_q;
  logic [3:0]  display_sel_q;
  logic [9:0]  ga_q;
  logic [9:0]  gb_q;
  logic        warn_q;
  logic        alarm_q;
  logic        run_q;
  logic        apply_q;
  logic [1:0]  settle_q;
  logic        block_q;
  // pin path
  logic [3:0]  s1_q;
  logic [3:0]  s2_q;
  logic [3:0]  s3_q;
  logic [3:0]  flt_q;
  logic [3:0]  old_q;
  // counting
  logic        fwd_q;
  logic        rev_q;
  logic        mstep_q;
  logic        mcw_q;
  logic signed [31:0] pos_q;
  logic signed [31:0] acc_q;

  wire bus_take = hsel & htrans[1] & hready;
  wire word_ok  = hsize == 3'h2;
  wire w_cfg  = wr_pend_q & (wr_addr_q == pcd_pkg::PCD_ADDR_CFG);
  wire w_gear = wr_pend_q & (wr_addr_q == pcd_pkg::PCD_ADDR_GEAR);
  wire w_enc  = wr_pend_q & (wr_addr_q == pcd_pkg::PCD_ADDR_ENC);
  wire w_ctrl = wr_pend_q & (wr_addr_q == pcd_pkg::PCD_ADDR_CTRL);
  wire [9:0] wd_den  = hwdata[pcd_pkg::PCD_DEN_LSB +: 10];
  wire [9:0] wd_num  = hwdata[pcd_pkg::PCD_NUM_LSB +: 10];
  wire [3:0] wd_disp = hwdata[pcd_pkg::PCD_CFG_DISP_LSB +: 4];
  wire den_ok  = (wd_den >= pcd_pkg::PCD_GEAR_MIN) && (wd_den <= pcd_pkg::PCD_GEAR_MAX);
  wire num_ok  = (wd_num >= pcd_pkg::PCD_GEAR_MIN) && (wd_num <= pcd_pkg::PCD_GEAR_MAX);
  wire disp_ok = wd_disp <= pcd_pkg::PCD_DISP_MAX;

  wire [31:0] rd_cfg = {20'h00000, cfg_disp_q, 2'h0, cfg_dir_q, cfg_ana_q,
                        cfg_pal_q, cfg_mode_q};
  wire [31:0] rd_gear = {6'h00, cnum_q, 6'h00, cden_q};
  wire [31:0] rd_enc  = {6'h00, enum_q, 6'h00, eden_q};
  wire [31:0] rd_stat = {12'h000, display_sel_q, 3'h0, flt_q[3], alarm_q,
                         warn_q, run_q, block_q, 1'h0, mode_q};
  wire [7:0]  ra = haddr[7:0];
  wire [31:0] rd_mux =
    (ra == pcd_pkg::PCD_ADDR_CFG)  ? rd_cfg  :
    (ra == pcd_pkg::PCD_ADDR_GEAR) ? rd_gear :
    (ra == pcd_pkg::PCD_ADDR_ENC)  ? rd_enc  :
    (ra == pcd_pkg::PCD_ADDR_STAT) ? rd_stat :
    (ra == pcd_pkg::PCD_ADDR_POS)  ? pos_q   : 32'h00000000;

  // zero-wait slave: read data captured at the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 8'h00;
      hrdata_q    <= 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end
    else
    begin
      wr_pend_q   <= bus_take & hwrite & word_ok;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
      if (bus_take)
        wr_addr_q <= ra;
      if (bus_take & ~hwrite)
        hrdata_q <= rd_mux;
    end
  end

  // out-of-range gear or display writes leave the field unchanged
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_mode_q <= pcd_pkg::PCD_MODE_RST;
      cfg_pal_q  <= pcd_pkg::PCD_PAL_RST;
      cfg_ana_q  <= pcd_pkg::PCD_ANA_RST;
      cfg_dir_q  <= pcd_pkg::PCD_DIR_RST;
      cfg_disp_q <= pcd_pkg::PCD_DISP_RST;
      cden_q     <= pcd_pkg::PCD_GEAR_RST;
      cnum_q     <= pcd_pkg::PCD_GEAR_RST;
      eden_q     <= pcd_pkg::PCD_GEAR_RST;
      enum_q     <= pcd_pkg::PCD_GEAR_RST;
    end
    else
    begin
      if (w_cfg)
      begin
        cfg_mode_q <= hwdata[pcd_pkg::PCD_CFG_MODE_LSB +: 3];
        cfg_pal_q  <= hwdata[pcd_pkg::PCD_CFG_PAL_BIT];
        cfg_ana_q  <= hwdata[pcd_pkg::PCD_CFG_ANA_BIT];
        cfg_dir_q  <= hwdata[pcd_pkg::PCD_CFG_DIR_BIT];
        if (disp_ok)
          cfg_disp_q <= wd_disp;
      end
      if (w_gear && den_ok)
        cden_q <= wd_den;
      if (w_gear && num_ok)
        cnum_q <= wd_num;
      if (w_enc && den_ok)
        eden_q <= wd_den;
      if (w_enc && num_ok)
        enum_q <= wd_num;
    end
  end

  // pins: three stages, a change counts once stages two and three agree
  wire [3:0] pin_raw = {input_mode_selector_switch, pos_req_in, dir_ccw_in,
                        step_pulse_in};
  wire [3:0] agree   = s2_q ~^ s3_q;
  wire [3:0] flt_d   = (agree & s2_q) | (~agree & flt_q);
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_q  <= 4'h0;
      s2_q  <= 4'h0;
      s3_q  <= 4'h0;
      flt_q <= 4'h0;
      old_q <= 4'h0;
    end
    else if (ce)
    begin
      s1_q  <= pin_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= flt_d;
      old_q <= flt_q;
    end
  end

  // next filtered level: the power-up latch lands on the same edge that flt_q catches up
  wire sw_on = flt_d[3];
  always_comb
  begin
    case (cfg_mode_q)
      pcd_pkg::PCD_CODE_SW:     mode_sel = sw_on ? pcd_pkg::PCD_STEP_N
                                                 : pcd_pkg::PCD_DUAL_N;
      pcd_pkg::PCD_CODE_DUAL_N: mode_sel = pcd_pkg::PCD_DUAL_N;
      pcd_pkg::PCD_CODE_DUAL_P: mode_sel = pcd_pkg::PCD_DUAL_P;
      pcd_pkg::PCD_CODE_STEP_N: mode_sel = pcd_pkg::PCD_STEP_N;
      pcd_pkg::PCD_CODE_STEP_P: mode_sel = pcd_pkg::PCD_STEP_P;
      pcd_pkg::PCD_CODE_QX1:    mode_sel = pcd_pkg::PCD_QX1;
      pcd_pkg::PCD_CODE_QX2:    mode_sel = pcd_pkg::PCD_QX2;
      pcd_pkg::PCD_CODE_QX4:    mode_sel = pcd_pkg::PCD_QX4;
      default:                  mode_sel = pcd_pkg::PCD_DUAL_N;
    endcase
  end

  // products stay below 2^27, no division needed
  wire [31:0] res_num = pcd_pkg::PCD_RES_BASE * {22'h000000, cnum_q};
  wire [31:0] res_lo  = pcd_pkg::PCD_RES_MIN * {22'h000000, cden_q};
  wire [31:0] res_hi  = pcd_pkg::PCD_RES_MAX * {22'h000000, cden_q};
  wire res_ok = (res_num >= res_lo) && (res_num <= res_hi);
  wire unsup  = (cfg_disp_q == pcd_pkg::PCD_DISP_TENS) ||
                (cfg_disp_q == pcd_pkg::PCD_DISP_ROLL);
  wire [3:0] disp_eff = unsup ? pcd_pkg::PCD_DISP_TOP : cfg_disp_q;
  // waits for the pin path to settle so the switch level is real
  wire latch = ce & apply_q & (settle_q == pcd_pkg::PCD_SETTLE);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mode_q        <= pcd_pkg::PCD_DUAL_N;
      pal_q         <= pcd_pkg::PCD_PAL_RST;
      dir_q         <= pcd_pkg::PCD_DIR_RST;
      analog_en_q   <= pcd_pkg::PCD_ANA_RST;
      display_sel_q <= pcd_pkg::PCD_DISP_RST;
      ga_q          <= pcd_pkg::PCD_GEAR_RST;
      gb_q          <= pcd_pkg::PCD_GEAR_RST;
      warn_q        <= 1'b0;
      alarm_q       <= 1'b0;
      run_q         <= 1'b0;
      apply_q       <= 1'b1;
      settle_q      <= 2'h0;
    end
    else
    begin
      apply_q <= (w_ctrl & hwdata[pcd_pkg::PCD_CTRL_APPLY]) | (apply_q & ~latch);
      if (ce && settle_q != pcd_pkg::PCD_SETTLE)
        settle_q <= settle_q + 2'h1;
      if (latch)
      begin
        mode_q        <= mode_sel;
        pal_q         <= cfg_pal_q;
        dir_q         <= cfg_dir_q;
        analog_en_q   <= cfg_ana_q;
        display_sel_q <= disp_eff;
        ga_q          <= cden_q;
        gb_q          <= cnum_q;
        warn_q        <= ~res_ok;
        alarm_q       <= alarm_q | warn_q;
        run_q         <= 1'b1;
      end
    end
  end

  // decoding
  wire neg  = (mode_q == pcd_pkg::PCD_DUAL_N) || (mode_q == pcd_pkg::PCD_STEP_N);
  wire a    = flt_q[0];
  wire b    = flt_q[1];
  wire ao   = old_q[0];
  wire bo   = old_q[1];
  wire as_n = a ^ neg;
  wire bs_n = b ^ neg;
  wire a_ast = as_n & ~(ao ^ neg);
  wire b_ast = bs_n & ~(bo ^ neg);
  wire a_rise = a & ~ao;
  wire a_fall = ~a & ao;
  wire b_rise = b & ~bo;
  wire b_fall = ~b & bo;
  wire q1_f = a_rise & ~b;
  wire q1_r = a_rise & b;
  wire q2_f = q1_f | (a_fall & b);
  wire q2_r = q1_r | (a_fall & ~b);
  wire q4_f = q2_f | (b_rise & a) | (b_fall & ~a);
  wire q4_r = q2_r | (b_rise & ~a) | (b_fall & a);
  wire is_step = (mode_q == pcd_pkg::PCD_STEP_N) || (mode_q == pcd_pkg::PCD_STEP_P);
  wire is_dual = (mode_q == pcd_pkg::PCD_DUAL_N) || (mode_q == pcd_pkg::PCD_DUAL_P);
  wire raw_f = is_step ? (a_ast & bs_n) :
               is_dual ? a_ast :
               (mode_q == pcd_pkg::PCD_QX1) ? q1_f :
               (mode_q == pcd_pkg::PCD_QX2) ? q2_f : q4_f;
  wire raw_r = is_step ? (a_ast & ~bs_n) :
               is_dual ? b_ast :
               (mode_q == pcd_pkg::PCD_QX1) ? q1_r :
               (mode_q == pcd_pkg::PCD_QX2) ? q2_r : q4_r;
  wire dec_en = ce & run_q & ~block_q & ~alarm_q;
  // opposing steps in one cycle cancel
  wire dec_f = dec_en & raw_f & ~raw_r;
  wire dec_r = dec_en & raw_r & ~raw_f;
  wire preq_rise = flt_q[2] & ~old_q[2];

  // gear: each input step adds the numerator, each motor step takes the denominator
  wire signed [31:0] den32  = {22'h000000, ga_q};
  wire signed [31:0] num32  = {22'h000000, gb_q};
  wire drn_f = acc_q >= den32;
  wire drn_r = acc_q <= -den32;
  wire signed [31:0] acc_in  = dec_f ? num32 : dec_r ? -num32 : 32'sh0;
  wire signed [31:0] acc_out = drn_f ? den32 : drn_r ? -den32 : 32'sh0;
  wire signed [31:0] acc_d   = acc_q + acc_in - acc_out;
  wire signed [31:0] pos_inc = dec_f ? 32'sh1 : dec_r ? -32'sh1 : 32'sh0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      block_q <= 1'b0;
      fwd_q   <= 1'b0;
      rev_q   <= 1'b0;
      mstep_q <= 1'b0;
      mcw_q   <= 1'b0;
      pos_q   <= 32'sh0;
      acc_q   <= 32'sh0;
    end
    else if (ce)
    begin
      // a new clear outranks a request edge in the same cycle
      block_q <= (abs_alarm_clr & ~pal_q) | (block_q & ~preq_rise);
      fwd_q   <= dec_f;
      rev_q   <= dec_r;
      pos_q   <= pos_q + pos_inc;
      acc_q   <= latch ? 32'sh0 : acc_d;
      mstep_q <= drn_f | drn_r;
      if (drn_f | drn_r)
        mcw_q <= drn_f ? dir_q : ~dir_q;
    end
  end

  assign hrdata      = hrdata_q;
  assign hreadyout   = hreadyout_q;
  assign hresp       = hresp_q;
  assign fwd_step    = fwd_q;
  assign rev_step    = rev_q;
  assign motor_step  = mstep_q;
  assign motor_cw    = mcw_q;
  assign analog_en   = analog_en_q;
  assign display_sel = display_sel_q;
  assign gear_warn   = warn_q;
  assign gear_alarm  = alarm_q;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_clr_hold;
    ce && abs_alarm_clr && !pal_q;
  endsequence
  sequence s_quiet;
    !fwd_q && !rev_q;
  endsequence

  AST_GEAR_RANGE: assert property (cden_q >= pcd_pkg::PCD_GEAR_MIN &&
    cden_q <= pcd_pkg::PCD_GEAR_MAX)
    else $error("command gear denominator out of range");
  AST_ENC_RANGE: assert property (eden_q >= pcd_pkg::PCD_GEAR_MIN &&
    eden_q <= pcd_pkg::PCD_GEAR_MAX && enum_q >= pcd_pkg::PCD_GEAR_MIN &&
    enum_q <= pcd_pkg::PCD_GEAR_MAX)
    else $error("encoder gear setting out of range");
  AST_SW_MODE: assert property (latch && cfg_mode_q == pcd_pkg::PCD_CODE_SW |=>
    mode_q == ($past(sw_on) ? pcd_pkg::PCD_STEP_N : pcd_pkg::PCD_DUAL_N))
    else $error("switch mode not taken at latch");
  AST_QX4: assert property (latch && cfg_mode_q == pcd_pkg::PCD_CODE_QX4 |=>
    mode_q == pcd_pkg::PCD_QX4)
    else $error("code 7 did not select x4");
  AST_BLOCK: assert property (s_clr_hold ##1 (ce && !preq_rise) |=> s_quiet)
    else $error("steps passed while blocked");
  AST_DIR: assert property (ce && drn_f |=> mstep_q && mcw_q == dir_q)
    else $error("forward motor step has wrong sense");
  AST_DISP: assert property (display_sel_q <= pcd_pkg::PCD_DISP_MAX &&
    display_sel_q != pcd_pkg::PCD_DISP_TENS && display_sel_q != pcd_pkg::PCD_DISP_ROLL)
    else $error("unsupported display selected");
  AST_STEP_FWD: assert property (dec_en && is_step && a_ast && bs_n |=> fwd_q && !rev_q)
    else $error("step pulse not counted forward");
  AST_Q_FWD: assert property (dec_en && mode_q == pcd_pkg::PCD_QX1 && a_rise && !b
    |=> fwd_q)
    else $error("quadrature forward missed");
  AST_Q_REV: assert property (dec_en && mode_q == pcd_pkg::PCD_QX4 && b_rise && !a
    |=> rev_q)
    else $error("quadrature reverse missed");
  AST_FREEZE: assert property (!latch |=> $stable(mode_q) && $stable(ga_q))
    else $error("active setting changed without latch");
  AST_WARN: assert property (latch && !res_ok |=> warn_q)
    else $error("gear warning not raised");
endmodule : pcd_top
`default_nettype wire

/* sim/pcd_pulse_src.sv */
// behavioural pulse source standing in for the controller at the pin side
`timescale 1ns/1ps
`default_nettype none
module pcd_pulse_src (
  input  wire logic clk,
  output logic      line_a,
  output logic      line_b,
  output logic      req
);
  // forward: channel b lags channel a by a quarter cycle
  logic [1:0] qf [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
  logic [1:0] qr [4] = '{2'b01, 2'b11, 2'b10, 2'b00};

  initial
  begin
    line_a = 1'b1;
    line_b = 1'b1;
    req    = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold

  // kind 0 dual, 1 step and sense, 2 quadrature; pos 1 means active high
  task automatic rest(input logic [1:0] kind, input logic pos);
    line_a <= (kind == 2'd2) ? 1'b0 : ~pos;
    line_b <= (kind == 2'd2) ? 1'b0 : ~pos;
    hold(8);
  endtask : rest

  task automatic send(input logic [1:0] kind, input logic pos, input logic fwd, input int n);
    for (int i = 0; i < n; i++)
    begin
      if (kind == 2'd2)
      begin
        for (int j = 0; j < 4; j++)
        begin
          {line_a, line_b} <= fwd ? qf[j] : qr[j];
          hold(4);
        end
      end
      else
      begin
        // sense settles a full pulse width ahead of the step edge
        if (kind == 2'd1)
        begin
          line_b <= fwd ? pos : ~pos;
          hold(4);
        end
        if (kind == 2'd1 || fwd)
        begin
          line_a <= pos;
          hold(4);
          line_a <= ~pos;
        end
        else
        begin
          line_b <= pos;
          hold(4);
          line_b <= ~pos;
        end
        hold(4);
      end
    end
    hold(8);
  endtask : send

  task automatic request();
    req <= 1'b1;
    hold(4);
    req <= 1'b0;
    hold(4);
  endtask : request
endmodule : pcd_pulse_src
`default_nettype wire

/* sim/pcd_top_bench.sv */
// self-checking bench: ahb-lite register tasks driving the decoder and pulse source
`timescale 1ns/1ps
`default_nettype none
module pcd_top_bench;
  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        fwd_step;
  logic        rev_step;
  logic        hsel;
  logic        hwrite;
  logic        alarm_clr;
  logic        sw;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rdv;
  logic        hreadyout;
  logic        hresp;
  logic        motor_step;
  logic        motor_cw;
  logic        analog_en;
  logic        gear_warn;
  logic        gear_alarm;
  logic [3:0]  display_sel;
  wire logic   line_a;
  wire logic   line_b;
  wire logic   req;
  int          bad_count = 0;
  int          n_compared = 0;
  int          m_cnt = 0;
  int          f_cnt = 0;
  int          r_cnt = 0;
  int          mul;
  int          mb;
  int          d;
  logic [1:0]  kind;
  logic        pol;

  pcd_top pcd_top_inst (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .step_pulse_in(line_a), .dir_ccw_in(line_b), .pos_req_in(req),
    .input_mode_selector_switch(sw), .abs_alarm_clr(alarm_clr), .fwd_step(fwd_step),
    .rev_step(rev_step), .motor_step(motor_step), .motor_cw(motor_cw), .analog_en(analog_en),
    .display_sel(display_sel), .gear_warn(gear_warn), .gear_alarm(gear_alarm)
  );

  pcd_pulse_src src_inst (.clk(hclk), .line_a(line_a), .line_b(line_b), .req(req));

  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  always @(posedge hclk) if (motor_step === 1'b1) m_cnt <= m_cnt + 1;
  always @(posedge hclk) if (fwd_step === 1'b1) f_cnt <= f_cnt + 1;
  always @(posedge hclk) if (rev_step === 1'b1) r_cnt <= r_cnt + 1;

  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // hready is sampled at the edge; a slave that never answers ends the run
  task automatic bus_wait();
    int k;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      bad_count++;
      $display("mismatch at %0t: bus wait ran out", $time);
      close_out();
    end
  endtask : bus_wait

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h000000, a};
    bus_wait();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    bus_wait();
    rdv = hrdata;
    // idle cycle so a following read sees the stored value
    @(posedge hclk);
  endtask : ahb

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] wd);
    ahb(1'b1, a, wd);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    ahb(1'b0, a, 32'h00000000);
  endtask : rd_reg

  task automatic mode(input logic [6:0] e, input string what);
    rd_reg(pcd_pkg::PCD_ADDR_STAT);
    check({25'h0000000, rdv[6:0]}, {25'h0000000, e}, what);
  endtask : mode

  task automatic apply(input logic [6:0] e);
    int k;
    wr_reg(pcd_pkg::PCD_ADDR_CTRL, 32'h00000001);
    k = 0;
    do
    begin
      rd_reg(pcd_pkg::PCD_ADDR_STAT);
      k++;
    end
    while (rdv[6:0] !== e && k < 40);
    repeat (10) @(posedge hclk);
    mode(e, "mode after reapply");
  endtask : apply

  task automatic steps(input logic [1:0] kd, input logic pl, input logic fw, input int n,
                       input logic [31:0] exp, input string what);
    logic [31:0] b;
    int          fb;
    int          rb;
    rd_reg(pcd_pkg::PCD_ADDR_POS);
    b = rdv;
    fb = f_cnt;
    rb = r_cnt;
    src_inst.send(kd, pl, fw, n);
    rd_reg(pcd_pkg::PCD_ADDR_POS);
    check(rdv - b, exp, what);
    check(32'(f_cnt - fb - (r_cnt - rb)), exp, what);
  endtask : steps

  task automatic rst();
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (8) @(posedge hclk);
  endtask : rst

  task automatic clear_alarm();
    alarm_clr <= 1'b1;
    @(posedge hclk);
    alarm_clr <= 1'b0;
    @(posedge hclk);
  endtask : clear_alarm

  initial
  begin
    repeat (100000) @(posedge hclk);
    bad_count++;
    $display("mismatch at %0t: run too long", $time);
    close_out();
  end

  initial
  begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    alarm_clr = 1'b0;
    sw = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    rst();
    rd_reg(pcd_pkg::PCD_ADDR_CFG);
    check(rdv, 32'h00000000, "cfg reset");
    rd_reg(pcd_pkg::PCD_ADDR_GEAR);
    check(rdv, 32'h00010001, "gear reset");
    rd_reg(pcd_pkg::PCD_ADDR_ENC);
    check(rdv, 32'h00010001, "enc reset");
    rd_reg(8'h18);
    check(rdv | {31'h00000000, hresp}, 32'h00000000, "unmapped read");
    mode(7'h01, "switch off mode");
    sw <= 1'b1;
    mode(7'h01, "switch change ignored");
    apply(7'h04);
    steps(2'd1, 1'b0, 1'b1, 3, 32'h00000003, "switch step fwd");
    steps(2'd1, 1'b0, 1'b0, 2, 32'hFFFFFFFE, "switch step rev");
    for (int c = 1; c < 8; c++)
    begin
      kind = (c < 3) ? 2'd0 : (c < 5) ? 2'd1 : 2'd2;
      pol = (c == 2 || c == 4);
      mul = (c == 6) ? 2 : (c == 7) ? 4 : 1;
      src_inst.rest(kind, pol);
      wr_reg(pcd_pkg::PCD_ADDR_CFG, 32'(c));
      if (c == 1) mode(7'h04, "cfg write not live");
      apply(7'(1 << (c - 1)));
      steps(kind, pol, 1'b1, 3, 32'(3 * mul), "fwd count");
      steps(kind, pol, 1'b0, 2, 32'(-2 * mul), "rev count");
    end
    src_inst.rest(2'd0, 1'b0);
    wr_reg(pcd_pkg::PCD_ADDR_CFG, 32'h00000001);
    wr_reg(pcd_pkg::PCD_ADDR_GEAR, 32'h00020001);
    apply(7'h01);
    mb = m_cnt;
    steps(2'd0, 1'b0, 1'b1, 3, 32'h00000003, "geared input");
    check(32'(m_cnt - mb), 32'h00000006, "motor steps 2/1");
    check({31'h0, motor_cw}, 32'h00000000, "fwd is ccw");
    wr_reg(pcd_pkg::PCD_ADDR_CFG, 32'h00000021);
    apply(7'h01);
    steps(2'd0, 1'b0, 1'b1, 1, 32'h00000001, "fwd dir1");
    check({31'h0, motor_cw}, 32'h00000001, "fwd is cw");
    steps(2'd0, 1'b0, 1'b0, 1, 32'hFFFFFFFF, "rev dir1");
    check({31'h0, motor_cw}, 32'h00000000, "rev is ccw");
    wr_reg(pcd_pkg::PCD_ADDR_GEAR, 32'h000203E9);
    rd_reg(pcd_pkg::PCD_ADDR_GEAR);
    check(rdv, 32'h00020001, "den 1001 refused");
    wr_reg(pcd_pkg::PCD_ADDR_GEAR, 32'h000003E8);
    rd_reg(pcd_pkg::PCD_ADDR_GEAR);
    check(rdv, 32'h000203E8, "den 1000 kept, num 0 refused");
    wr_reg(pcd_pkg::PCD_ADDR_ENC, 32'h03E80000);
    rd_reg(pcd_pkg::PCD_ADDR_ENC);
    check(rdv, 32'h03E80001, "enc num 1000, den 0 refused");
    wr_reg(pcd_pkg::PCD_ADDR_GEAR, 32'h0001000A);
    apply(7'h01);
    check({31'h0, gear_warn}, 32'h00000000, "resolution 100 valid");
    wr_reg(pcd_pkg::PCD_ADDR_GEAR, 32'h0001000B);
    apply(7'h01);
    check({30'h0, gear_alarm, gear_warn}, 32'h00000001, "resolution 90 warns");
    apply(7'h01);
    check({31'h0, gear_alarm}, 32'h00000001, "reapply alarms");
    steps(2'd0, 1'b0, 1'b1, 2, 32'h00000000, "alarm blocks");
    rst();
    check({30'h0, gear_alarm, gear_warn}, 32'h00000000, "reset clears");
    mode(7'h04, "switch read at reset");
    for (int i = 0; i < 4; i++)
    begin
      d = 6 + i;
      wr_reg(pcd_pkg::PCD_ADDR_CFG, {20'h00000, d[3:0], 8'h10});
      apply(7'h04);
      check({28'h0, display_sel}, (d == 6 || d == 8) ? 32'h9 : 32'(d), "display");
      check({31'h0, analog_en}, 32'h00000001, "analog on");
    end
    wr_reg(pcd_pkg::PCD_ADDR_CFG, 32'h00000A00);
    rd_reg(pcd_pkg::PCD_ADDR_CFG);
    check(rdv, 32'h00000900, "display 10 refused, analog 0 kept");
    apply(7'h04);
    check({31'h0, analog_en}, 32'h00000000, "analog off");
    wr_reg(pcd_pkg::PCD_ADDR_CFG, 32'h00000001);
    apply(7'h01);
    clear_alarm();
    steps(2'd0, 1'b0, 1'b1, 2, 32'h00000000, "blocked after clear");
    src_inst.request();
    steps(2'd0, 1'b0, 1'b1, 2, 32'h00000002, "released by request");
    wr_reg(pcd_pkg::PCD_ADDR_CFG, 32'h00000009);
    apply(7'h01);
    clear_alarm();
    steps(2'd0, 1'b0, 1'b1, 2, 32'h00000002, "accept at once");
    ce <= 1'b0;
    steps(2'd0, 1'b0, 1'b1, 2, 32'h00000000, "frozen by enable");
    ce <= 1'b1;
    steps(2'd0, 1'b0, 1'b1, 1, 32'h00000001, "running again");
    close_out();
  end
endmodule : pcd_top_bench
`default_nettype wire
